// >>> logic/eps_pkg.sv
package eps_pkg;
   // ==========================================================
   // widths
   localparam int ST_W   = 18;
   localparam int REV_W  = 12;
   localparam int POS_W  = 30;
   localparam int TOT_W  = 31;
   localparam int STEP_W = 19;
   localparam int SH_W   = 4;
   localparam int FR_W   = 16;
   localparam int ACC_W  = 80;
   localparam int ADR_W  = 6;
   // ==========================================================
   // limits
   localparam logic [STEP_W-1:0] STEPS_MAX = 19'h40000;
   localparam logic [SH_W-1:0]   SHIFT_MAX = 4'hC;
   localparam logic [TOT_W-1:0]  TOTAL_MAX = 31'h40000000;
   // ==========================================================
   // register byte offsets
   localparam logic [ADR_W-1:0] A_CTRL   = 6'h00;
   localparam logic [ADR_W-1:0] A_STEPS  = 6'h04;
   localparam logic [ADR_W-1:0] A_TSHIFT = 6'h08;
   localparam logic [ADR_W-1:0] A_RTOTAL = 6'h0C;
   localparam logic [ADR_W-1:0] A_NUM    = 6'h10;
   localparam logic [ADR_W-1:0] A_DEN    = 6'h14;
   localparam logic [ADR_W-1:0] A_PRESET = 6'h18;
   localparam logic [ADR_W-1:0] A_OFFSET = 6'h1C;
   localparam logic [ADR_W-1:0] A_POS    = 6'h20;
   localparam logic [ADR_W-1:0] A_STATUS = 6'h24;
   // ==========================================================
   // field positions
   localparam int B_ROUND = 0;
   localparam int B_SEQ   = 1;
   localparam int B_PREJ  = 0;
   localparam int B_BUSY  = 1;
   localparam int B_CREJ  = 2;
   // ==========================================================
   // reset values
   localparam logic [STEP_W-1:0] STEPS_RST  = 19'h40000;
   localparam logic [SH_W-1:0]   SHIFT_RST  = 4'hC;
   localparam logic [TOT_W-1:0]  RTOTAL_RST = 31'h40000000;
   localparam logic [FR_W-1:0]   NUM_RST    = 16'h0001;
   localparam logic [FR_W-1:0]   DEN_RST    = 16'h0001;

   typedef enum logic {EPS_IDLE, EPS_STEP} eps_state_e;
endpackage

// >>> logic/eps_scaler.sv
// What this block does
// - steps per revolution is accepted from 1 to 262,144 and scales the singleturn position to that many steps.
// - the raw singleturn position from the code disk is 18 bits wide in both variants.
// - the multiturn variant counts revolutions in 12 bits while the singleturn variant has no revolution count.
// - the multiturn combined position spans at most 30 bits of total resolution.
// - outside round-axis mode the total resolution is a power-of-two multiple of steps per revolution.
// - a preset inside the measuring range makes the output equal it by holding offset = preset - real position.
// - reset clears the offset; offs_save and offs_val hand it out for storage, and once it is written back the output is the new real position plus that offset.
// - the output applies zero-point offset, code sequence and gear parameters together.
// - round-axis mode ignores steps per revolution and uses total resolution with numerator and denominator.
// - round-axis output counts 0 to total minus one over the fractional span and then wraps to 0.
`timescale 1ns/1ps
module eps_scaler
   import eps_pkg::*;
#(
   parameter bit MULTITURN = 1'b1
)
(
   input  wire logic              sys_clk,    // system clock
   input  wire logic              srst,       // sync reset
   input  wire logic [ST_W-1:0]   raw_st,     // code disk angle
   input  wire logic [REV_W-1:0]  raw_rev,    // revolution count
   input  wire logic              raw_valid,  // raw sample strobe
   input  wire logic [ADR_W-1:0]  reg_addr,   // byte address
   input  wire logic [31:0]       reg_wdata,  // write data
   input  wire logic              reg_wr,     // write strobe
   input  wire logic              reg_rd,     // read strobe
   output logic      [31:0]       reg_rdata,  // read data
   output logic      [POS_W-1:0]  pos_out,    // output position
   output logic                   offs_save,  // offset changed
   output logic      [POS_W-1:0]  offs_val    // offset to store
);
   // ==========================================================
   // state
   logic [ST_W-1:0]   st_ff, nxt_st;
   logic [REV_W-1:0]  rev_ff, nxt_rev;
   logic              round_ff, nxt_round;
   logic              seq_ff, nxt_seq;
   logic [STEP_W-1:0] steps_ff, nxt_steps;
   logic [SH_W-1:0]   tsh_ff, nxt_tsh;
   logic [TOT_W-1:0]  rtot_ff, nxt_rtot;
   logic [FR_W-1:0]   num_ff, nxt_num;
   logic [FR_W-1:0]   den_ff, nxt_den;
   logic [TOT_W-1:0]  offs_ff, nxt_offs;
   logic [POS_W-1:0]  pos_ff, nxt_pos;
   logic [31:0]       rdata_ff, nxt_rdata;
   logic              save_ff, nxt_save;
   logic              prej_ff, nxt_prej;
   logic              crej_ff, nxt_crej;
   logic [POS_W-1:0]  cnt_ff, nxt_cnt;
   logic [POS_W-1:0]  last_ff, nxt_last;
   logic signed [ACC_W-1:0] acc_ff, nxt_acc;
   eps_state_e        state_ff, nxt_state;

   logic [TOT_W-1:0]  tot, revm, real_p, real_d, sum, pre_off, wval;
   logic [36:0]       scl;
   logic [POS_W-1:0]  absp, delta;
   logic [46:0]       kmul;
   logic signed [ACC_W-1:0] dx, kx, prod, dvs;
   logic              cfg_ok, cfg_wr, busy;

   assign busy      = (state_ff == EPS_STEP);
   assign reg_rdata = rdata_ff;
   assign pos_out   = pos_ff;
   assign offs_save = save_ff;
   assign offs_val  = offs_ff[POS_W-1:0];

   // ==========================================================
   // next state
   always_comb
   begin
      nxt_st    = st_ff;
      nxt_rev   = rev_ff;
      nxt_round = round_ff;
      nxt_seq   = seq_ff;
      nxt_steps = steps_ff;
      nxt_tsh   = tsh_ff;
      nxt_rtot  = rtot_ff;
      nxt_num   = num_ff;
      nxt_den   = den_ff;
      nxt_offs  = offs_ff;
      nxt_prej  = prej_ff;
      nxt_crej  = crej_ff;
      nxt_cnt   = cnt_ff;
      nxt_last  = last_ff;
      nxt_acc   = acc_ff;
      nxt_state = state_ff;
      nxt_rdata = 32'h00000000;
      cfg_ok    = 1'b0;
      cfg_wr    = 1'b0;
      wval      = reg_wdata[TOT_W-1:0];

      if (raw_valid)
      begin
         nxt_st = raw_st;
         nxt_rev = MULTITURN ? raw_rev : '0;
      end

      tot = round_ff ? rtot_ff : (TOT_W'(steps_ff) << tsh_ff);
      revm   = TOT_W'(rev_ff) & ((TOT_W'(1) << tsh_ff) - TOT_W'(1));
      scl    = 37'(st_ff) * 37'(steps_ff);
      real_p = round_ff ? TOT_W'(cnt_ff) : (revm * TOT_W'(steps_ff)) + TOT_W'(scl >> ST_W);
      real_d = (seq_ff && real_p != '0) ? tot - real_p : real_p;
      sum    = real_d + offs_ff;
      if (sum >= tot)
         sum = sum - tot;
      nxt_pos = sum[POS_W-1:0];
      pre_off = (wval >= real_d) ? wval - real_d : wval + tot - real_d;

      absp  = {rev_ff, st_ff};
      delta = absp - last_ff;
      kmul  = 47'(rtot_ff) * 47'(den_ff);
      dx    = ACC_W'($signed(delta));
      kx    = ACC_W'(kmul);
      prod  = dx * kx;
      dvs   = ACC_W'({num_ff, 18'h00000});
      case (state_ff)
         EPS_IDLE:
         begin
            if (round_ff && absp != last_ff)
            begin
               nxt_acc   = acc_ff + prod;
               nxt_last  = absp;
               nxt_state = EPS_STEP;
            end
         end
         EPS_STEP:
         begin
            if (acc_ff >= dvs)
            begin
               nxt_acc = acc_ff - dvs;
               nxt_cnt = (TOT_W'(cnt_ff) == rtot_ff - TOT_W'(1)) ? '0 : cnt_ff + POS_W'(1);
            end
            else if (acc_ff < 0)
            begin
               nxt_acc = acc_ff + dvs;
               nxt_cnt = (cnt_ff == '0) ? POS_W'(rtot_ff - TOT_W'(1)) : cnt_ff - POS_W'(1);
            end
            else
               nxt_state = EPS_IDLE;
         end
         default: nxt_state = EPS_IDLE;
      endcase

      if (reg_wr)
      begin
         case (reg_addr)
            A_CTRL:
            begin
               cfg_ok    = 1'b1;
               nxt_round = MULTITURN & reg_wdata[B_ROUND];
               nxt_seq   = reg_wdata[B_SEQ];
            end
            A_STEPS:
            begin
               cfg_ok = (reg_wdata != 32'h00000000) && (reg_wdata <= 32'(STEPS_MAX));
               if (cfg_ok)
                  nxt_steps = reg_wdata[STEP_W-1:0];
            end
            A_TSHIFT:
            begin
               // cap keeps total within 30 bits
               cfg_ok = reg_wdata <= (MULTITURN ? 32'(SHIFT_MAX) : 32'h00000000);
               if (cfg_ok)
                  nxt_tsh = reg_wdata[SH_W-1:0];
            end
            A_RTOTAL:
            begin
               cfg_ok = (reg_wdata != 32'h00000000) && (reg_wdata <= 32'(TOTAL_MAX));
               if (cfg_ok)
                  nxt_rtot = wval;
            end
            A_NUM:
            begin
               cfg_ok = (reg_wdata[31:FR_W] == '0) && (reg_wdata != 32'h00000000);
               if (cfg_ok)
                  nxt_num = reg_wdata[FR_W-1:0];
            end
            A_DEN:
            begin
               cfg_ok = (reg_wdata[31:FR_W] == '0) && (reg_wdata != 32'h00000000);
               if (cfg_ok)
                  nxt_den = reg_wdata[FR_W-1:0];
            end
            A_PRESET:
            begin
               if (reg_wdata < 32'(tot))
                  nxt_offs = pre_off;
               else
                  nxt_prej = 1'b1;
            end
            A_OFFSET:
            begin
               if (reg_wdata < 32'(tot))
                  nxt_offs = wval;
               else
                  nxt_crej = 1'b1;
            end
            A_STATUS:
            begin
               nxt_prej = prej_ff & ~reg_wdata[B_PREJ];
               nxt_crej = crej_ff & ~reg_wdata[B_CREJ];
            end
            default: nxt_offs = offs_ff;
         endcase
         cfg_wr = (reg_addr == A_CTRL) || (reg_addr == A_STEPS) || (reg_addr == A_TSHIFT)
                  || (reg_addr == A_RTOTAL) || (reg_addr == A_NUM) || (reg_addr == A_DEN);
         if (cfg_wr && !cfg_ok)
            nxt_crej = 1'b1;
         // new scaling restarts from absolute zero
         if (cfg_ok)
         begin
            nxt_offs  = '0;
            nxt_cnt   = '0;
            nxt_acc   = '0;
            nxt_last  = '0;
            nxt_state = EPS_IDLE;
         end
      end

      if (reg_rd)
      begin
         case (reg_addr)
            A_CTRL:   nxt_rdata = {30'h00000000, seq_ff, round_ff};
            A_STEPS:  nxt_rdata = 32'(steps_ff);
            A_TSHIFT: nxt_rdata = 32'(tsh_ff);
            A_RTOTAL: nxt_rdata = 32'(rtot_ff);
            A_NUM:    nxt_rdata = 32'(num_ff);
            A_DEN:    nxt_rdata = 32'(den_ff);
            A_OFFSET: nxt_rdata = 32'(offs_ff);
            A_POS:    nxt_rdata = 32'(pos_ff);
            A_STATUS: nxt_rdata = {29'h00000000, crej_ff, busy, prej_ff};
            default:  nxt_rdata = 32'h00000000;
         endcase
      end
      nxt_save = (nxt_offs != offs_ff);
   end

   // ==========================================================
   // registers
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         st_ff    <= '0;
         rev_ff   <= '0;
         round_ff <= 1'b0;
         seq_ff   <= 1'b0;
         steps_ff <= STEPS_RST;
         tsh_ff   <= MULTITURN ? SHIFT_RST : 4'h0;
         rtot_ff  <= RTOTAL_RST;
         num_ff   <= NUM_RST;
         den_ff   <= DEN_RST;
         offs_ff  <= '0;
         pos_ff   <= '0;
         rdata_ff <= 32'h00000000;
         save_ff  <= 1'b0;
         prej_ff  <= 1'b0;
         crej_ff  <= 1'b0;
         cnt_ff   <= '0;
         last_ff  <= '0;
         acc_ff   <= '0;
         state_ff <= EPS_IDLE;
      end
      else
      begin
         st_ff    <= nxt_st;
         rev_ff   <= nxt_rev;
         round_ff <= nxt_round;
         seq_ff   <= nxt_seq;
         steps_ff <= nxt_steps;
         tsh_ff   <= nxt_tsh;
         rtot_ff  <= nxt_rtot;
         num_ff   <= nxt_num;
         den_ff   <= nxt_den;
         offs_ff  <= nxt_offs;
         pos_ff   <= nxt_pos;
         rdata_ff <= nxt_rdata;
         save_ff  <= nxt_save;
         prej_ff  <= nxt_prej;
         crej_ff  <= nxt_crej;
         cnt_ff   <= nxt_cnt;
         last_ff  <= nxt_last;
         acc_ff   <= nxt_acc;
         state_ff <= nxt_state;
      end
   end

   // ==========================================================
   // checks
   steps_range_a: assert property (@(posedge sys_clk) disable iff (srst)
      steps_ff != '0 && steps_ff <= STEPS_MAX)
      else $error("steps per revolution out of range");

   st_norev_a: assert property (@(posedge sys_clk) disable iff (srst)
      raw_valid && !srst |=> rev_ff == (MULTITURN ? $past(raw_rev) : REV_W'(0)) && (MULTITURN || tsh_ff == '0))
      else $error("singleturn shows revolutions");

   total_cap_a: assert property (@(posedge sys_clk) disable iff (srst)
      tot <= TOTAL_MAX && tsh_ff <= SHIFT_MAX)
      else $error("total resolution above 30 bits");

   pos_range_a: assert property (@(posedge sys_clk) disable iff (srst)
      !$past(srst) && !$past(cfg_ok) |-> TOT_W'(pos_ff) < $past(tot))
      else $error("position beyond total resolution");

   round_count_a: assert property (@(posedge sys_clk) disable iff (srst)
      round_ff |-> TOT_W'(cnt_ff) < rtot_ff)
      else $error("round count beyond total");

   remainder_a: assert property (@(posedge sys_clk) disable iff (srst)
      state_ff == EPS_IDLE && round_ff |-> acc_ff >= 0 && acc_ff < dvs)
      else $error("round remainder not normalised");

   preset_hit_a: assert property (@(posedge sys_clk) disable iff (srst)
      reg_wr && reg_addr == A_PRESET && reg_wdata < 32'(tot) && !round_ff && (!raw_valid || raw_st == st_ff
      && (raw_rev == rev_ff || !MULTITURN)) |-> ##2 pos_ff == $past(reg_wdata[POS_W-1:0], 2))
      else $error("preset not reflected at output");

   preset_rej_a: assert property (@(posedge sys_clk) disable iff (srst)
      reg_wr && reg_addr == A_PRESET && reg_wdata >= 32'(tot) |=> prej_ff && $stable(offs_ff))
      else $error("bad preset not refused");

   offs_save_a: assert property (@(posedge sys_clk) disable iff (srst)
      !$past(srst) && offs_ff != $past(offs_ff) |-> offs_save && offs_val == offs_ff[POS_W-1:0])
      else $error("offset change not flagged for storage");
endmodule

// >>> test/eps_disk_model.sv
`timescale 1ns/1ps
// ==========================================================
// code disk front end, samples every other cycle
module eps_disk_model
   import eps_pkg::*;
(
   input  wire logic             sys_clk,    // system clock
   input  wire logic [POS_W-1:0] shaft_pos,  // absolute shaft angle
   output logic      [ST_W-1:0]  raw_st,     // code disk angle
   output logic      [REV_W-1:0] raw_rev,    // turn count
   output logic                  raw_valid   // sample strobe
);
   logic tog_ff = 1'b0;
   always_ff @(posedge sys_clk)
   begin
      tog_ff    <= ~tog_ff;
      raw_valid <= tog_ff;
      raw_st    <= tog_ff ? shaft_pos[ST_W-1:0] : ~shaft_pos[ST_W-1:0];
      raw_rev   <= tog_ff ? shaft_pos[POS_W-1:ST_W] : ~shaft_pos[POS_W-1:ST_W];
   end
endmodule

// >>> test/encoder_position_scaling_tb.sv
`timescale 1ns/1ps
module encoder_position_scaling_tb
   import eps_pkg::*;
;
   logic              sys_clk, srst, reg_wr, reg_rd, raw_valid, offs_save;
   logic [ADR_W-1:0]  reg_addr;
   logic [31:0]       reg_wdata, reg_rdata, d;
   logic [ST_W-1:0]   raw_st;
   logic [REV_W-1:0]  raw_rev;
   logic [POS_W-1:0]  pos_out, offs_val, shaft_pos;
   int                error_cnt, n_compared, save_cnt, i, n;
   longint            stp, tot, p, off, acc, dd;
   logic [ADR_W-1:0]  ra [7] = '{A_STEPS, A_TSHIFT, A_RTOTAL, A_CTRL, A_NUM, A_DEN, 6'h3C};
   logic [31:0]       rv [7] = '{32'h40000, 32'hC, 32'h40000000, 32'h0, 32'h1, 32'h1, 32'h0};
   // ==========================================================
   // clock, design and far side
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   eps_scaler #(.MULTITURN(1'b1)) i_eps_scaler (.sys_clk(sys_clk), .srst(srst), .raw_st(raw_st),
      .raw_rev(raw_rev), .raw_valid(raw_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pos_out(pos_out),
      .offs_save(offs_save), .offs_val(offs_val));
   eps_disk_model i_eps_disk_model (.sys_clk(sys_clk), .shaft_pos(shaft_pos), .raw_st(raw_st),
      .raw_rev(raw_rev), .raw_valid(raw_valid));
   always @(posedge sys_clk)
   begin
      if (offs_save === 1'b1)
         save_cnt++;
   end
   // ==========================================================
   // helpers
   function automatic longint real_pos(longint a, longint s, int sh);
      return ((a >> 18) % (64'd1 << sh)) * s + ((a % 262144) * s) / 262144;
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (e !== g)
      begin
         error_cnt++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic wr(logic [ADR_W-1:0] a, logic [31:0] v);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(logic [ADR_W-1:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic settle();
      repeat (8) @(posedge sys_clk);
      #1;
   endtask
   task automatic wait_idle();
      int k;
      settle();
      for (k = 0; k < 3000; k++)
      begin
         rd(A_STATUS, d);
         if (d[B_BUSY] === 1'b0)
            break;
      end
      chk("busy_wait", 32'h0, 32'(k == 3000));
      #1;
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #(40 * 80000);
      error_cnt++;
      give_verdict();
   end
   // ==========================================================
   // main sequence
   initial
   begin
      srst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      shaft_pos = '0;
      error_cnt = 0;
      n_compared = 0;
      save_cnt = 0;
      void'($urandom(36));
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      for (i = 0; i < 7; i++)
      begin
         rd(ra[i], d);
         chk("reset_value", rv[i], d);
      end
      for (i = 0; i < 6; i++)
      begin
         stp = (i == 0) ? 262144 : (i == 1) ? 1 : 1 + $urandom_range(262143);
         n = $urandom_range(12);
         wr(A_STEPS, 32'(stp));
         wr(A_TSHIFT, 32'(n));
         shaft_pos <= 30'($urandom());
         settle();
         chk("scaled_pos", 32'(real_pos(shaft_pos, stp, n)), 32'(pos_out));
      end
      wr(A_STEPS, 32'h0);
      rd(A_STEPS, d);
      chk("steps_zero_refused", 32'(stp), d);
      wr(A_TSHIFT, 32'hD);
      rd(A_TSHIFT, d);
      chk("shift_refused", 32'(n), d);
      tot = stp << n;
      p = $urandom_range(32'(tot - 1));
      off = (p - real_pos(shaft_pos, stp, n) + tot) % tot;
      i = save_cnt;
      wr(A_PRESET, 32'(p));
      settle();
      chk("preset_pos", 32'(p), 32'(pos_out));
      chk("preset_offset", 32'(off), 32'(offs_val));
      chk("offset_saved", 32'(i + 1), 32'(save_cnt));
      wr(A_PRESET, 32'(tot));
      settle();
      chk("preset_reject_offset", 32'(off), 32'(offs_val));
      rd(A_STATUS, d);
      chk("preset_reject_flag", 32'h1, 32'(d[B_PREJ]));
      wr(A_STATUS, 32'h7);
      srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      shaft_pos <= 30'($urandom());
      off = $urandom_range(32'h3FFFFFFF);
      wr(A_OFFSET, 32'(off));
      settle();
      chk("restored_pos", 32'((shaft_pos + off) % 1073741824), 32'(pos_out));
      wr(A_CTRL, 32'h2);
      settle();
      chk("inverted_pos", 32'((1073741824 - shaft_pos) % 1073741824), 32'(pos_out));
      shaft_pos <= '0;
      wr(A_RTOTAL, 32'd1000);
      wr(A_NUM, 32'd1);
      wr(A_DEN, 32'd9);
      wr(A_CTRL, 32'h1);
      settle();
      chk("round_start", 32'h0, 32'(pos_out));
      acc = 0;
      for (i = 0; i < 20; i++)
      begin
         dd = 5003 + $urandom_range(200);
         // every fourth move turns back
         if (i % 4 == 3)
            dd = 3000 - dd;
         acc += dd;
         shaft_pos <= shaft_pos + 30'(dd);
         wait_idle();
         chk("round_pos", 32'(((acc * 9000) / 262144) % 1000), 32'(pos_out));
      end
      wr(A_PRESET, 32'd500);
      settle();
      chk("round_preset", 32'd500, 32'(pos_out));
      give_verdict();
   end
endmodule
